// File: core/apc_pkg.sv
package apc_pkg;

    // register map and reset values
    localparam logic [7:0] APC_REG_MASTER_CFG = 8'h13;
    localparam logic [7:0] APC_REG_RATE_RATIO = 8'h14;
    localparam logic [7:0] APC_REG_MON_STS    = 8'h15;
    localparam logic [7:0] APC_RST_MASTER_CFG = 8'h02;
    localparam logic [7:0] APC_RST_RATE_RATIO = 8'h48;
    localparam logic [7:0] APC_RST_MON_STS    = 8'hff;
    localparam logic [7:0] APC_RD_UNMAPPED    = 8'h00;

    localparam logic [3:0] APC_RATE_INVALID   = 4'hf;
    localparam logic [3:0] APC_RATIO_INVALID  = 4'hf;
    localparam int         APC_RATE_CODES     = 9;
    localparam int         APC_RATIO_CODES    = 13;

    // clock and timing
    localparam int         APC_CLK_PERIOD_NS  = 4;
    localparam longint     APC_NS_PER_S       = 64'h3b9aca00;
    localparam longint     APC_NS_PER_US      = 64'h3e8;
    localparam longint     APC_REF_HZ         = APC_NS_PER_S / APC_CLK_PERIOD_NS;
    localparam longint     APC_MON_TIMEOUT_US = 64'h3e8;
    localparam longint     APC_MON_TIMEOUT_CYC =
        APC_MON_TIMEOUT_US * APC_NS_PER_US / APC_CLK_PERIOD_NS;
    localparam int         APC_MON_TOL_SHIFT  = 6;

    typedef struct packed {
        logic       master;
        logic       auto_dis;
        logic       pll_off;
        logic       gate;
        logic       family;
        logic [2:0] ref_code;
    } apc_mst_cfg_s;

    typedef struct packed {
        logic [3:0] rate;
        logic [3:0] ratio;
    } apc_rate_cfg_s;

    typedef struct packed {
        logic        pll_en;
        logic        ref_valid;
        logic [31:0] ref_hz;
        logic [3:0]  rate;
        logic [3:0]  ratio;
        logic        family;
    } apc_plan_s;

    function automatic logic [19:0] apc_fs_hz(input logic [3:0] code,
                                              input logic       fam);
        logic [19:0] v;
        v = 20'h0;
        case ({fam, code})
            5'h00: v = 20'h01f40;
            5'h01: v = 20'h03e80;
            5'h02: v = 20'h05dc0;
            5'h03: v = 20'h07d00;
            5'h04: v = 20'h0bb80;
            5'h05: v = 20'h17700;
            5'h06: v = 20'h2ee00;
            5'h07: v = 20'h5dc00;
            5'h08: v = 20'hbb800;
            5'h10: v = 20'h01cb6;
            5'h11: v = 20'h0396c;
            5'h12: v = 20'h05622;
            5'h13: v = 20'h072d8;
            5'h14: v = 20'h0ac44;
            5'h15: v = 20'h15888;
            5'h16: v = 20'h2b110;
            5'h17: v = 20'h56220;
            5'h18: v = 20'hac440;
            default: v = 20'h0;
        endcase
        return v;
    endfunction : apc_fs_hz

    function automatic logic [11:0] apc_ratio_val(input logic [3:0] code);
        logic [11:0] v;
        v = 12'h0;
        case (code)
            4'h0: v = 12'h010;
            4'h1: v = 12'h018;
            4'h2: v = 12'h020;
            4'h3: v = 12'h030;
            4'h4: v = 12'h040;
            4'h5: v = 12'h060;
            4'h6: v = 12'h080;
            4'h7: v = 12'h0c0;
            4'h8: v = 12'h100;
            4'h9: v = 12'h180;
            4'ha: v = 12'h200;
            4'hb: v = 12'h400;
            4'hc: v = 12'h800;
            default: v = 12'h0;
        endcase
        return v;
    endfunction : apc_ratio_val

    function automatic logic [31:0] apc_mclk_hz(input logic [2:0] code);
        logic [31:0] v;
        v = 32'h0;
        case (code)
            3'h0: v = 32'h00b71b00;
            3'h1: v = 32'h00bb8000;
            3'h2: v = 32'h00c65d40;
            3'h3: v = 32'h00f42400;
            3'h4: v = 32'h0124f800;
            3'h5: v = 32'h012c4b00;
            3'h6: v = 32'h016e3600;
            default: v = 32'h01770000;
        endcase
        return v;
    endfunction : apc_mclk_hz

    function automatic logic [11:0] apc_mclk_ratio(input logic [2:0] code);
        logic [11:0] v;
        v = 12'h0;
        case (code)
            3'h0: v = 12'h040;
            3'h1: v = 12'h100;
            3'h2: v = 12'h180;
            3'h3: v = 12'h200;
            3'h4: v = 12'h300;
            3'h5: v = 12'h400;
            3'h6: v = 12'h600;
            default: v = 12'h900;
        endcase
        return v;
    endfunction : apc_mclk_ratio

endpackage : apc_pkg

// File: core/apc_rate_monitor.sv
`timescale 1ns/1ns
module apc_rate_monitor #(
    parameter longint TIMEOUT_CYC = apc_pkg::APC_MON_TIMEOUT_CYC,
    parameter int     CNT_W       = $clog2(TIMEOUT_CYC + 1)
) (
    input  wire logic          ref_clk,
    input  wire logic          reset_n,
    input  wire logic          bclk_rise,
    input  wire logic          frame_sync_rise,
    output logic [3:0]         rate_code,
    output logic [3:0]         ratio_code
);
    import apc_pkg::*;

    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
    localparam logic [CNT_W-1:0] CNT_END = CNT_W'(TIMEOUT_CYC - 1);
    localparam logic [11:0]      BIT_MAX = 12'hfff;
    localparam logic [63:0]      REF_W   = 64'(APC_REF_HZ);
    localparam logic [63:0]      TOL_W   = 64'(APC_REF_HZ >> APC_MON_TOL_SHIFT);

    logic [CNT_W-1:0] per_q;
    logic [11:0]      bits_q;
    logic             seen_q;
    logic [3:0]       rate_q;
    logic [3:0]       ratio_q;
    logic [3:0]       rate_hit;
    logic [3:0]       ratio_hit;
    logic             timeout;
    logic [11:0]      bits_now;

    assign timeout  = (per_q == CNT_END);
    assign bits_now = bclk_rise && (bits_q != BIT_MAX) ? bits_q + 12'h1 : bits_q;

    // period times nominal rate must land near the reference rate
    always_comb begin
        logic [63:0] prod;
        logic [63:0] diff;
        prod     = 64'h0;
        diff     = 64'h0;
        rate_hit = APC_RATE_INVALID;
        for (int i = 0; i < APC_RATE_CODES; i++) begin
            for (int f = 0; f < 2; f++) begin
                prod = 64'(per_q + CNT_ONE) * 64'(apc_fs_hz(4'(i), f[0]));
                diff = prod > REF_W ? prod - REF_W : REF_W - prod;
                if (diff <= TOL_W) begin
                    rate_hit = 4'(i);
                end
            end
        end
    end

    always_comb begin
        ratio_hit = APC_RATIO_INVALID;
        for (int j = 0; j < APC_RATIO_CODES; j++) begin
            if (apc_ratio_val(4'(j)) == bits_now) begin
                ratio_hit = 4'(j);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            per_q   <= '0;
            bits_q  <= 12'h0;
            seen_q  <= 1'b0;
            rate_q  <= APC_RATE_INVALID;
            ratio_q <= APC_RATIO_INVALID;
        end else if (frame_sync_rise) begin
            per_q  <= '0;
            bits_q <= 12'h0;
            seen_q <= 1'b1;
            if (seen_q) begin
                rate_q  <= rate_hit;
                ratio_q <= ratio_hit;
            end
        end else if (timeout) begin
            // stopped clocks fall back to invalid codes
            per_q   <= '0;
            bits_q  <= 12'h0;
            seen_q  <= 1'b0;
            rate_q  <= APC_RATE_INVALID;
            ratio_q <= APC_RATIO_INVALID;
        end else begin
            per_q  <= per_q + CNT_ONE;
            bits_q <= bits_now;
        end
    end

    assign rate_code  = rate_q;
    assign ratio_code = ratio_q;

    AST_TIMEOUT_INVALID: assert property (@(posedge ref_clk)
        disable iff (!reset_n) timeout && !frame_sync_rise |=>
        rate_code == APC_RATE_INVALID && ratio_code == APC_RATIO_INVALID)
        else $error("monitor did not go invalid on timeout");

    AST_RATE_CODE_SET: assert property (@(posedge ref_clk)
        disable iff (!reset_n) rate_code < 4'h9 || rate_code == APC_RATE_INVALID)
        else $error("detected rate holds a reserved code");

    AST_RATIO_CODE_SET: assert property (@(posedge ref_clk)
        disable iff (!reset_n)
        ratio_code < 4'hd || ratio_code == APC_RATIO_INVALID)
        else $error("detected ratio holds a reserved code");

    COV_RATE_FOUND: cover property (@(posedge ref_clk)
        disable iff (!reset_n) $changed(rate_code) && rate_code != APC_RATE_INVALID);

endmodule : apc_rate_monitor

// File: core/apc_port_clock.sv
`timescale 1ns/1ns
module apc_port_clock #(
    parameter longint MON_TIMEOUT_CYC = apc_pkg::APC_MON_TIMEOUT_CYC
) (
    input  wire logic              ref_clk,
    input  wire logic              reset_n,
    input  wire logic              reg_wr_en,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    output logic [7:0]             reg_rdata,
    input  wire logic              ref_clock_spec_mode,
    input  wire logic [2:0]        ref_to_frame_ratio_code,
    input  wire logic              custom_pll_en,
    input  wire logic              bclk_in,
    output logic                   bclk_out,
    output logic                   bclk_oe,
    input  wire logic              frame_sync_in,
    output logic                   frame_sync_out,
    output logic                   frame_sync_oe,
    output apc_pkg::apc_plan_s     clk_plan
);
    import apc_pkg::*;

    localparam logic [33:0] REF_34 = 34'(APC_REF_HZ);

    apc_mst_cfg_s  mst_q;
    apc_rate_cfg_s rr_q;
    logic [7:0]    rdata_q;
    logic [3:0]    det_rate;
    logic [3:0]    det_ratio;
    apc_plan_s     plan_q;
    apc_plan_s     plan_d;

    // register port
    logic wr_mst;
    logic wr_rr;
    logic [7:0] rd_mux;
    assign wr_mst = reg_wr_en && (reg_addr == APC_REG_MASTER_CFG);
    assign wr_rr  = reg_wr_en && (reg_addr == APC_REG_RATE_RATIO);
    assign rd_mux = (reg_addr == APC_REG_MASTER_CFG) ? mst_q :
                    (reg_addr == APC_REG_RATE_RATIO) ? rr_q :
                    (reg_addr == APC_REG_MON_STS) ? {det_rate, det_ratio} :
                    APC_RD_UNMAPPED;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            mst_q   <= APC_RST_MASTER_CFG;
            rr_q    <= APC_RST_RATE_RATIO;
            rdata_q <= APC_RD_UNMAPPED;
        end else begin
            if (wr_mst) begin
                mst_q <= reg_wdata;
            end
            if (wr_rr) begin
                rr_q <= reg_wdata;
            end
            rdata_q <= rd_mux;
        end
    end
    assign reg_rdata = rdata_q;

    // pin synchronisers: s1 feeds s2 only, level moves once s2 and s3 agree
    logic [2:0] bclk_s_q;
    logic [2:0] frame_sync_s_q;
    logic       bclk_lvl_q;
    logic       frame_sync_lvl_q;
    logic       bclk_rise;
    logic       frame_sync_rise;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            bclk_s_q    <= 3'h0;
            frame_sync_s_q   <= 3'h0;
            bclk_lvl_q  <= 1'b0;
            frame_sync_lvl_q <= 1'b0;
        end else begin
            bclk_s_q  <= {bclk_s_q[1:0], bclk_in};
            frame_sync_s_q <= {frame_sync_s_q[1:0], frame_sync_in};
            if (bclk_s_q[1] == bclk_s_q[2]) begin
                bclk_lvl_q <= bclk_s_q[2];
            end
            if (frame_sync_s_q[1] == frame_sync_s_q[2]) begin
                frame_sync_lvl_q <= frame_sync_s_q[2];
            end
        end
    end
    assign bclk_rise  = (bclk_s_q[1] == bclk_s_q[2]) && bclk_s_q[2] && !bclk_lvl_q;
    assign frame_sync_rise = (frame_sync_s_q[1] == frame_sync_s_q[2]) && frame_sync_s_q[2] &&
                        !frame_sync_lvl_q;

    // monitor watches the wire in both modes, so master output is checked too
    apc_rate_monitor #(
        .TIMEOUT_CYC (MON_TIMEOUT_CYC)
    ) u_mon (
        .ref_clk    (ref_clk),
        .reset_n    (reset_n),
        .bclk_rise  (bclk_rise),
        .frame_sync_rise (frame_sync_rise),
        .rate_code  (det_rate),
        .ratio_code (det_ratio)
    );

    // effective plan
    logic        auto_mode;
    logic        slave_auto;
    logic [19:0] fs_eff;
    assign auto_mode  = !mst_q.auto_dis;
    assign slave_auto = !mst_q.master && auto_mode;

    always_comb begin
        plan_d        = '0;
        plan_d.family = mst_q.family;
        // slave auto follows what the monitor sees, not the programmed codes
        plan_d.rate   = slave_auto ? det_rate : rr_q.rate;
        plan_d.ratio  = slave_auto ? det_ratio : rr_q.ratio;
        plan_d.pll_en = auto_mode ? !mst_q.pll_off : custom_pll_en;
        if (mst_q.master) begin
            plan_d.ref_valid = 1'b1;
            if (ref_clock_spec_mode) begin
                plan_d.ref_hz = 32'(fs_eff * apc_mclk_ratio(
                    ref_to_frame_ratio_code));
            end else begin
                plan_d.ref_hz = apc_mclk_hz(mst_q.ref_code);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            plan_q <= '0;
        end else begin
            plan_q <= plan_d;
        end
    end
    assign clk_plan = plan_q;

    // master clock generator: fractional accumulator at twice the bit rate
    assign fs_eff = apc_fs_hz(rr_q.rate, mst_q.family);
    logic [11:0] ratio_eff;
    logic [33:0] inc;
    logic [33:0] acc_q;
    logic [33:0] acc_d;
    logic [33:0] acc_sum;
    logic        tick;
    logic        gen_on;
    logic        bclk_q;
    logic        frame_sync_q;
    logic [11:0] bit_q;
    logic [11:0] bit_d;

    assign ratio_eff = apc_ratio_val(rr_q.ratio);
    assign inc       = 34'({fs_eff, 1'b0}) * 34'(ratio_eff);
    // reserved codes give zero increments and the port stays idle
    assign gen_on    = mst_q.master && !mst_q.gate && (inc != 34'h0);
    assign acc_sum   = acc_q + inc;
    // rates beyond half the ref clock saturate at one toggle a cycle
    assign tick      = gen_on && ((inc >= REF_34) || (acc_sum >= REF_34));
    assign acc_d     = !gen_on ? 34'h0 :
                       (inc >= REF_34) ? 34'h0 :
                       tick ? acc_sum - REF_34 : acc_sum;
    // a shorter ratio wraps at once instead of running out to the top
    assign bit_d     = (bit_q >= ratio_eff - 12'h1) ? 12'h0 : bit_q + 12'h1;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            acc_q   <= 34'h0;
            bclk_q  <= 1'b0;
            frame_sync_q <= 1'b0;
            bit_q   <= 12'h0;
        end else if (!gen_on) begin
            acc_q   <= 34'h0;
            bclk_q  <= 1'b0;
            frame_sync_q <= 1'b0;
            bit_q   <= 12'h0;
        end else begin
            acc_q <= acc_d;
            if (tick) begin
                bclk_q <= !bclk_q;
                // new bit launched on the falling edge, frame mark on bit 0
                if (bclk_q) begin
                    bit_q   <= bit_d;
                    frame_sync_q <= (bit_d == 12'h0);
                end
            end
        end
    end

    assign bclk_out  = bclk_q;
    assign frame_sync_out = frame_sync_q;
    assign bclk_oe   = mst_q.master;
    assign frame_sync_oe  = mst_q.master;

    AST_SLAVE_NO_DRIVE: assert property (@(posedge ref_clk)
        disable iff (!reset_n) $past(wr_mst) && !mst_q.master |->
        !bclk_oe && !frame_sync_oe)
        else $error("pins driven in slave mode");

    // slowest legal rate bounds how long the bit clock may stay parked
    localparam logic [11:0] IDLE_LIMIT = 12'(APC_REF_HZ /
        (2 * apc_fs_hz(4'h0, 1'b1) * apc_ratio_val(4'h0)) + 1);
    logic [11:0] idle_q;

    always_ff @(posedge ref_clk) begin
        if (!reset_n || !gen_on || tick) begin
            idle_q <= 12'h0;
        end else begin
            idle_q <= idle_q + 12'h1;
        end
    end

    AST_MASTER_TOGGLE: assert property (@(posedge ref_clk)
        disable iff (!reset_n) gen_on |-> idle_q < IDLE_LIMIT)
        else $error("master bit clock stalled");

    AST_GATE_LOW: assert property (@(posedge ref_clk)
        disable iff (!reset_n) mst_q.master && mst_q.gate && !wr_mst |=>
        !bclk_out && !frame_sync_out && bclk_oe)
        else $error("gated master clocks still run");

    AST_PLL_OFF: assert property (@(posedge ref_clk)
        disable iff (!reset_n) !mst_q.auto_dis && mst_q.pll_off |=>
        !clk_plan.pll_en)
        else $error("pll left on in auto mode");

    AST_AUTO_PLL: assert property (@(posedge ref_clk)
        disable iff (!reset_n) !mst_q.auto_dis && !mst_q.pll_off |=>
        clk_plan.pll_en)
        else $error("auto mode did not enable pll");

    AST_REF_IGNORED: assert property (@(posedge ref_clk)
        disable iff (!reset_n) !mst_q.master |=>
        !clk_plan.ref_valid && clk_plan.ref_hz == 32'h0)
        else $error("reference used outside master mode");

    AST_REF_TABLE: assert property (@(posedge ref_clk)
        disable iff (!reset_n) mst_q.master && !ref_clock_spec_mode &&
        mst_q.ref_code == 3'h2 |=> clk_plan.ref_hz == 32'h00c65d40)
        else $error("reference code 2 not 13 MHz");

    AST_SPEC_MODE: assert property (@(posedge ref_clk)
        disable iff (!reset_n) mst_q.master && ref_clock_spec_mode &&
        rr_q.rate == 4'h4 && !mst_q.family &&
        ref_to_frame_ratio_code == 3'h1 |=> clk_plan.ref_hz == 32'h00bb8000)
        else $error("frame multiple reference wrong");

    AST_SLAVE_AUTO: assert property (@(posedge ref_clk)
        disable iff (!reset_n) slave_auto |=>
        clk_plan.rate == $past(det_rate) && clk_plan.ratio == $past(det_ratio))
        else $error("slave auto used programmed codes");

    AST_FAMILY: assert property (@(posedge ref_clk)
        disable iff (!reset_n) ##1 clk_plan.family == $past(mst_q.family))
        else $error("family select not carried");

    AST_FRAME_LEN: assert property (@(posedge ref_clk)
        disable iff (!reset_n) gen_on && tick && bclk_q && frame_sync_q |->
        bit_q == 12'h0)
        else $error("frame sync off bit zero");

    AST_STS_RESET: assert property (@(posedge ref_clk)
        !reset_n |=> det_rate == APC_RATE_INVALID &&
        det_ratio == APC_RATIO_INVALID)
        else $error("status not all ones after reset");

    AST_SLAVE_NO_GEN: assert property (@(posedge ref_clk)
        disable iff (!reset_n) !mst_q.master |=> !bclk_out && !frame_sync_out)
        else $error("slave mode generated port clocks");

    AST_STS_READ: assert property (@(posedge ref_clk)
        disable iff (!reset_n) reg_addr == APC_REG_MON_STS |=>
        reg_rdata == {$past(det_rate), $past(det_ratio)})
        else $error("status read lost detected codes");

    AST_RR_WRITE: assert property (@(posedge ref_clk)
        disable iff (!reset_n) wr_rr |=> rr_q == $past(reg_wdata))
        else $error("rate and ratio write lost");

    COV_MASTER_FRAME: cover property (@(posedge ref_clk)
        disable iff (!reset_n) gen_on ##1 $rose(frame_sync_out));
    COV_GATED: cover property (@(posedge ref_clk)
        disable iff (!reset_n) mst_q.master && mst_q.gate);
    COV_SLAVE_AUTO: cover property (@(posedge ref_clk)
        disable iff (!reset_n) slave_auto && det_rate != APC_RATE_INVALID);
    COV_FAMILY_44K: cover property (@(posedge ref_clk)
        disable iff (!reset_n) gen_on && mst_q.family);

endmodule : apc_port_clock

// File: tb/apc_host_model.sv
`timescale 1ns/1ns
module apc_host_model (
    input  wire logic        ref_clk,
    input  wire logic        en,
    input  wire logic [7:0]  half_cyc,
    input  wire logic [11:0] bits,
    output logic             bclk,
    output logic             frame_sync
);
    logic [7:0]  hcnt_q;
    logic [11:0] bit_q;
    // lines stand still low outside a run, never a stale level
    always_ff @(posedge ref_clk) begin
        if (!en) begin
            hcnt_q <= 8'h00;
            bit_q  <= 12'h000;
            bclk   <= 1'b0;
            frame_sync  <= 1'b0;
        // a shorter setting mid-run wraps at once rather than at the top
        end else if (hcnt_q >= half_cyc - 8'h01) begin
            hcnt_q <= 8'h00;
            bclk   <= ~bclk;
            if (bclk) begin
                // frame sync moves on the falling edge, high for bit 0
                bit_q <= (bit_q >= bits - 12'h001) ? 12'h000 : bit_q + 12'h001;
                frame_sync <= (bit_q >= bits - 12'h001);
            end
        end else begin
            hcnt_q <= hcnt_q + 8'h01;
        end
    end
endmodule : apc_host_model

// File: tb/apc_port_clock_test.sv
`timescale 1ns/1ns
module apc_port_clock_test;
    import apc_pkg::*;
    localparam logic [31:0] MHZ [8] = '{32'h00b71b00, 32'h00bb8000,
        32'h00c65d40, 32'h00f42400, 32'h0124f800, 32'h012c4b00,
        32'h016e3600, 32'h01770000};
    logic        ref_clk, reset_n, reg_wr_en, spec_mode, pll_en_in;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, half_cyc;
    logic [2:0]  frame_code;
    logic [11:0] bits;
    logic        bclk_out, bclk_oe, frame_sync_out, frame_sync_oe;
    logic        host_en, host_bclk, host_frame_sync;
    apc_plan_s   clk_plan;
    int          error_cnt, checks_done, n, bad;
    // the pin level: whoever drives it
    wire bclk_w  = bclk_oe ? bclk_out : host_bclk;
    wire frame_sync_w = frame_sync_oe ? frame_sync_out : host_frame_sync;

    apc_port_clock #(.MON_TIMEOUT_CYC(8000)) DUT (
        .ref_clk(ref_clk), .reset_n(reset_n), .reg_wr_en(reg_wr_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .ref_clock_spec_mode(spec_mode),
        .ref_to_frame_ratio_code(frame_code), .custom_pll_en(pll_en_in),
        .bclk_in(bclk_w), .bclk_out(bclk_out), .bclk_oe(bclk_oe),
        .frame_sync_in(frame_sync_w), .frame_sync_out(frame_sync_out), .frame_sync_oe(frame_sync_oe),
        .clk_plan(clk_plan));
    apc_host_model HOST (.ref_clk(ref_clk), .en(host_en),
        .half_cyc(half_cyc), .bits(bits), .bclk(host_bclk),
        .frame_sync(host_frame_sync));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    task automatic pause(input int c);
        repeat (c) @(posedge ref_clk);
        #1;
    endtask : pause

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        pause(1);
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        pause(1);
        reg_wr_en = 1'b0;
        pause(3);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        pause(1);
        reg_addr = a;
        pause(1);
        chk({24'h0, reg_rdata}, {24'h0, exp});
    endtask : rd

    // bounded poll; a miss ends the run
    task automatic wait_sts(input logic [7:0] exp);
        reg_addr = APC_REG_MON_STS;
        pause(2);
        for (n = 0; n < 30000 && reg_rdata !== exp; n++) pause(1);
        chk({24'h0, reg_rdata}, {24'h0, exp});
        if (reg_rdata !== exp) end_of_test();
    endtask : wait_sts

    task automatic host(input logic [7:0] h, input logic [11:0] b);
        half_cyc = h;
        bits = b;
        host_en = 1'b1;
    endtask : host

    initial begin
        {reset_n, reg_wr_en, spec_mode, pll_en_in, host_en} = 5'b0;
        {reg_addr, reg_wdata, frame_code} = 19'h0;
        {half_cyc, bits, error_cnt, checks_done} = '0;
        pause(2);
        reset_n = 1'b1;
        rd(APC_REG_MASTER_CFG, 8'h02);
        rd(APC_REG_RATE_RATIO, 8'h48);
        rd(APC_REG_MON_STS, 8'hff);
        rd(8'h40, 8'h00);
        wr(APC_REG_MON_STS, 8'h00);
        rd(APC_REG_MON_STS, 8'hff);
        chk({30'h0, bclk_oe, frame_sync_oe}, 32'h0);
        chk({31'h0, clk_plan.ref_valid}, 32'h0);
        chk({31'h0, clk_plan.pll_en}, 32'h1);
        // slave traffic: 48k by 32, then 192k by 16
        host(8'd81, 12'd32);
        wait_sts(8'h42);
        wr(APC_REG_RATE_RATIO, 8'h6a);
        chk({28'h0, clk_plan.rate}, 32'h4);
        chk({28'h0, clk_plan.ratio}, 32'h2);
        host(8'd41, 12'd16);
        wait_sts(8'h60);
        host(8'd33, 12'd20);
        wait_sts(8'h6f);
        host(8'd30, 12'd16);
        wait_sts(8'hf0);
        host_en = 1'b0;
        wait_sts(8'hff);
        wr(APC_REG_MASTER_CFG, 8'h22);
        chk({31'h0, clk_plan.pll_en}, 32'h0);
        pll_en_in = 1'b1;
        wr(APC_REG_MASTER_CFG, 8'h42);
        chk({31'h0, clk_plan.pll_en}, 32'h1);
        pll_en_in = 1'b0;
        pause(3);
        chk({31'h0, clk_plan.pll_en}, 32'h0);
        // master: 192k by 32, every reference code
        wr(APC_REG_RATE_RATIO, 8'h62);
        for (int c = 0; c < 8; c++) begin
            wr(APC_REG_MASTER_CFG, {5'b10000, 3'(c)});
            chk(clk_plan.ref_hz, MHZ[c]);
        end
        chk({30'h0, bclk_oe, frame_sync_oe}, 32'h3);
        chk({31'h0, clk_plan.ref_valid}, 32'h1);
        chk({24'h0, clk_plan.rate, clk_plan.ratio}, 32'h62);
        spec_mode = 1'b1;
        frame_code = 3'h2;
        pause(3);
        chk(clk_plan.ref_hz, 32'h04650000);
        wait_sts(8'h62);
        wr(APC_REG_MASTER_CFG, 8'h8f);
        chk({31'h0, clk_plan.family}, 32'h1);
        wr(APC_REG_MASTER_CFG, 8'h97);
        pause(50);
        bad = 0;
        for (n = 0; n < 2000; n++) begin
            pause(1);
            if ({bclk_out, frame_sync_out, bclk_oe} !== 3'b001) bad++;
        end
        chk(bad, 0);
        wait_sts(8'hff);
        end_of_test();
    end
endmodule : apc_port_clock_test
